// ---- verilog/lbh_defines.svh ----
`ifndef LBH_DEFINES_SVH
`define LBH_DEFINES_SVH
// Notes on behaviour
// - word address carries bits 31:2, driven by whichever side is master.
// - 32-bit data bus; its direction follows the master's read/write control.
// - master drives four active-low byte enables, enable 3 for bits 31:24.
// - master drives read/write low for a read, high for a write.
// - initiator drives read/write and strobe, target drives ready, all on the link clock.
// - master asserts address strobe low in a transaction's first cycle.
// - data ready going low ends the current transaction.
// - retry aborts the transaction, it is reissued later; retry is clocked.
// - requester raises hold request synchronously to the rising link clock.
// - under hold acknowledge the external master drives the control lines.

// ************************************************************
// link widths and ratios
// ************************************************************
`define LBH_ADDR_W 30
`define LBH_DATA_W 32
`define LBH_BE_W 4
`define LBH_CMD_W 67
`define LBH_FIFO_DEPTH 4
`define LBH_DIV_FAST 2
`define LBH_DIV_SLOW 4

// ************************************************************
// reset values of pin outputs
// ************************************************************
`define LBH_CTRL_IDLE 1'h1
`define LBH_BE_IDLE 4'hf
`define LBH_SLAVE_DATA_RST 32'h00000000
`endif

// ---- verilog/lbh_pkg.sv ----
`include "lbh_defines.svh"
package lbh_pkg;
  typedef logic [`LBH_ADDR_W-1:0] lbh_addr_t;
  typedef logic [`LBH_DATA_W-1:0] lbh_data_t;
  typedef logic [`LBH_BE_W-1:0] lbh_be_t;

  // one queued master transfer; beN is active low
  typedef struct packed {
    logic write;
    lbh_addr_t addr;
    lbh_be_t beN;
    lbh_data_t data;
  } lbh_cmd_t;

  typedef enum logic [2:0] {
    L_IDLE, L_HOLD, L_ADDR, L_WAIT, L_GAP, L_DROP, L_SLAVE
  } lbh_link_state_t;
endpackage

// ---- verilog/lbh_stream_if.sv ----
interface lbh_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/lbh_fifo.sv ----
module lbh_fifo #(
  parameter int WIDTH = 67,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams
  lbh_stream_if.snk wr,
  lbh_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrIdx;
  logic [AW-1:0] rdIdx;
  logic [AW:0] count;
  logic readyReg;

  wire push = wr.valid && readyReg;
  wire pop = rd.valid && rd.ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // ready is registered so the top port comes from a flop
  assign wr.ready = readyReg;
  assign rd.valid = count != '0;
  assign rd.data = mem[rdIdx];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrIdx] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
      readyReg <= 1'b0;
    end else begin
      wrIdx <= wrIdx + AW'(push);
      rdIdx <= rdIdx + AW'(pop);
      count <= next_count;
      readyReg <= next_count != (AW+1)'(DEPTH);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count == (AW+1)'(DEPTH) |-> !readyReg)
    else $error("fifo ready while full");
endmodule

// ---- verilog/lbh_host.sv ----
`include "lbh_defines.svh"
module lbh_host #(
  parameter int FIFO_DEPTH = `LBH_FIFO_DEPTH
) (
  // system side
  input wire logic sys_clk,
  input wire logic srst,
  // straps toward the device
  input wire logic cfgSlowLink,
  input wire logic testDividerReset,
  output logic lbus_speed_select_n,
  output logic lbus_divider_reset_n,
  // command stream
  input wire logic cmdValid,
  output logic cmdReady,
  input wire lbh_pkg::lbh_cmd_t cmdWord,
  // response
  output logic rspValid,
  output lbh_pkg::lbh_data_t rspData,
  output logic rspRetried,
  // link clock made by the device
  input wire logic lbus_clock,
  // address
  input wire lbh_pkg::lbh_addr_t lbus_word_address_in,
  output lbh_pkg::lbh_addr_t lbus_word_address_out,
  output logic lbus_word_address_oe,
  // data
  input wire lbh_pkg::lbh_data_t lbus_data_in,
  output lbh_pkg::lbh_data_t lbus_data_out,
  output logic lbus_data_oe,
  // byte enables
  input wire lbh_pkg::lbh_be_t lbus_byte_enable_n_in,
  output lbh_pkg::lbh_be_t lbus_byte_enable_n_out,
  output logic lbus_byte_enable_n_oe,
  // control
  input wire logic lbus_read_write_n_in,
  output logic lbus_read_write_n_out,
  output logic lbus_read_write_n_oe,
  input wire logic lbus_addr_strobe_n_in,
  output logic lbus_addr_strobe_n_out,
  output logic lbus_addr_strobe_n_oe,
  input wire logic lbus_ready_n_in,
  output logic lbus_ready_n_out,
  output logic lbus_ready_n_oe,
  input wire logic lbus_retry_n_in,
  output logic lbus_retry_n_out,
  // ownership
  output logic lbus_hold_request,
  input wire logic lbus_hold_ack
);
  import lbh_pkg::*;

  // ************************************************************
  // system domain: queue and hand-off
  // ************************************************************
  lbh_stream_if #(.WIDTH(`LBH_CMD_W)) inS ();
  lbh_stream_if #(.WIDTH(`LBH_CMD_W)) outS ();

  assign inS.valid = cmdValid;
  assign inS.data = cmdWord;
  assign cmdReady = inS.ready;

  lbh_fifo #(.WIDTH(`LBH_CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(srst),
    .wr(inS),
    .rd(outS)
  );

  lbh_cmd_t cmdHold;
  logic busy;
  logic reqTgl;
  logic [2:0] ackSync;
  logic ackSeen;
  logic ackTgl;
  lbh_data_t linkRdData;
  logic linkRetried;

  // one transfer in flight; the held word stays still until acknowledged
  assign outS.ready = !busy;
  wire take = outS.valid && !busy;
  wire ackAgree = ackSync[1] == ackSync[2];
  wire ackEvent = ackAgree && (ackSync[2] != ackSeen);

  always_ff @(posedge sys_clk) begin
    ackSync <= {ackSync[1:0], ackTgl};
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy <= 1'b0;
      reqTgl <= 1'b0;
      ackSeen <= 1'b0;
      cmdHold <= '0;
    end else begin
      if (take) begin
        cmdHold <= outS.data;
        reqTgl <= ~reqTgl;
        busy <= 1'b1;
      end else if (ackEvent) begin
        busy <= 1'b0;
      end
      if (ackEvent) begin
        ackSeen <= ackSync[2];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rspValid <= 1'b0;
      rspData <= '0;
      rspRetried <= 1'b0;
    end else begin
      rspValid <= ackEvent;
      if (ackEvent) begin
        rspData <= linkRdData;
        rspRetried <= linkRetried;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lbus_divider_reset_n <= 1'b1;
      lbus_speed_select_n <= 1'b0;
    end else begin
      lbus_divider_reset_n <= !testDividerReset;
      lbus_speed_select_n <= cfgSlowLink;
    end
  end

  // ************************************************************
  // link domain: bus ownership and transfers
  // ************************************************************
  logic [2:0] rstSync;
  logic linkRst;
  logic [2:0] reqSync;
  logic reqSeen;
  lbh_link_state_t state;
  logic slaveRead;
  lbh_data_t slaveData;
  logic retried;

  wire reqAgree = reqSync[1] == reqSync[2];
  wire reqEvent = reqAgree && (reqSync[2] != reqSeen);
  wire devStrobe = !lbus_hold_ack && !lbus_addr_strobe_n_in;
  wire slaveWrite = devStrobe && lbus_read_write_n_in;
  wire masterDone = !lbus_ready_n_in;
  wire masterRetry = !lbus_retry_n_in && lbus_ready_n_in;

  always_ff @(posedge lbus_clock) begin
    rstSync <= {rstSync[1:0], srst};
    reqSync <= {reqSync[1:0], reqTgl};
    if (rstSync[1] == rstSync[2]) begin
      linkRst <= rstSync[2];
    end
  end

  // writes from the device land per byte lane
  for (genvar b = 0; b < `LBH_BE_W; b++) begin : g_lane
    always_ff @(posedge lbus_clock) begin
      if (linkRst) begin
        slaveData[8*b +: 8] <= 8'h00;
      end else if (slaveWrite && state == L_IDLE
                   && !lbus_byte_enable_n_in[b]) begin
        slaveData[8*b +: 8] <= lbus_data_in[8*b +: 8];
      end
    end
  end

  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      state <= L_IDLE;
      reqSeen <= 1'b0;
      ackTgl <= 1'b0;
      slaveRead <= 1'b0;
      retried <= 1'b0;
      linkRdData <= '0;
      linkRetried <= 1'b0;
    end else begin
      unique case (state)
        L_IDLE: begin
          if (devStrobe) begin
            slaveRead <= !lbus_read_write_n_in;
            state <= L_SLAVE;
          end else if (reqEvent) begin
            reqSeen <= reqSync[2];
            retried <= 1'b0;
            state <= L_HOLD;
          end
        end
        L_SLAVE: state <= L_IDLE;
        // device may still be mastering; wait for acknowledge
        L_HOLD: if (lbus_hold_ack) state <= L_ADDR;
        L_ADDR: state <= L_WAIT;
        L_WAIT: begin
          if (masterDone) begin
            linkRdData <= lbus_data_in;
            linkRetried <= retried;
            state <= L_DROP;
          // abandon and reissue after a gap
          end else if (masterRetry) begin
            retried <= 1'b1;
            state <= L_GAP;
          end
        end
        L_GAP: state <= L_ADDR;
        L_DROP: begin
          if (!lbus_hold_ack) begin
            ackTgl <= ~ackTgl;
            state <= L_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // pin drivers, all registered on the link clock
  // ************************************************************
  wire masterNext = state == L_HOLD && lbus_hold_ack
                    || state == L_GAP
                    || state == L_ADDR
                    || state == L_WAIT && !masterDone;
  wire strobeNext = state == L_HOLD && lbus_hold_ack || state == L_GAP;
  wire slaveNext = state == L_IDLE && devStrobe;

  // request raised and kept until our transfer has ended
  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      lbus_hold_request <= 1'b0;
    end else begin
      lbus_hold_request <= (state == L_IDLE && !devStrobe && reqEvent)
        || (lbus_hold_request && !(state == L_WAIT && masterDone))
           && state != L_DROP;
    end
  end

  // address, enables and direction while master
  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      lbus_word_address_out <= '0;
      lbus_byte_enable_n_out <= `LBH_BE_IDLE;
      lbus_read_write_n_out <= `LBH_CTRL_IDLE;
      lbus_word_address_oe <= 1'b0;
      lbus_byte_enable_n_oe <= 1'b0;
      lbus_read_write_n_oe <= 1'b0;
      lbus_addr_strobe_n_oe <= 1'b0;
    end else begin
      lbus_word_address_out <= cmdHold.addr;
      lbus_byte_enable_n_out <= cmdHold.beN;
      lbus_read_write_n_out <= cmdHold.write;
      lbus_word_address_oe <= masterNext;
      lbus_byte_enable_n_oe <= masterNext;
      lbus_read_write_n_oe <= masterNext;
      lbus_addr_strobe_n_oe <= masterNext;
    end
  end

  // strobe for the first cycle only
  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      lbus_addr_strobe_n_out <= `LBH_CTRL_IDLE;
    end else begin
      lbus_addr_strobe_n_out <= !strobeNext;
    end
  end

  // data direction: our write as master, or a device read of us
  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      lbus_data_out <= '0;
      lbus_data_oe <= 1'b0;
    end else begin
      lbus_data_out <= slaveNext ? slaveData : cmdHold.data;
      lbus_data_oe <= masterNext && cmdHold.write
        || slaveNext && !lbus_read_write_n_in && !lbus_hold_request;
    end
  end

  // slave answers: ready, or retry when we want the bus
  always_ff @(posedge lbus_clock) begin
    if (linkRst) begin
      lbus_ready_n_out <= `LBH_CTRL_IDLE;
      lbus_ready_n_oe <= 1'b0;
      lbus_retry_n_out <= `LBH_CTRL_IDLE;
    end else begin
      lbus_ready_n_out <= !(slaveNext && !lbus_hold_request);
      lbus_ready_n_oe <= slaveNext && !lbus_hold_request;
      lbus_retry_n_out <= !(state == L_HOLD && devStrobe);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_strobe;
    lbus_addr_strobe_n_oe && !lbus_addr_strobe_n_out;
  endsequence

  // the gap cycle registers the new strobe, so it shows while in L_ADDR
  sequence s_reissue;
    state == L_GAP ##1 state == L_ADDR && !lbus_addr_strobe_n_out;
  endsequence

  a_strobe_one_cycle: assert property (@(posedge lbus_clock)
    disable iff (linkRst) s_strobe |=> lbus_addr_strobe_n_out)
    else $error("address strobe longer than one cycle");

  a_addr_at_strobe: assert property (@(posedge lbus_clock)
    disable iff (linkRst) s_strobe |-> lbus_word_address_oe
      && lbus_word_address_out == $past(cmdHold.addr))
    else $error("address not driven with strobe");

  a_be_at_strobe: assert property (@(posedge lbus_clock)
    disable iff (linkRst) s_strobe |-> lbus_byte_enable_n_oe
      && lbus_byte_enable_n_out == $past(cmdHold.beN))
    else $error("byte enables not driven with strobe");

  a_rdwr_polarity: assert property (@(posedge lbus_clock)
    disable iff (linkRst) s_strobe |-> lbus_read_write_n_oe
      && lbus_read_write_n_out == $past(cmdHold.write))
    else $error("read/write level wrong");

  a_data_direction: assert property (@(posedge lbus_clock)
    disable iff (linkRst) lbus_data_oe |->
      (lbus_read_write_n_oe && lbus_read_write_n_out) || lbus_ready_n_oe)
    else $error("data driven against direction");

  a_drive_needs_hold: assert property (@(posedge lbus_clock)
    disable iff (linkRst) lbus_addr_strobe_n_oe |-> lbus_hold_request)
    else $error("control driven without hold request");

  a_retry_reissue: assert property (@(posedge lbus_clock)
    disable iff (linkRst) state == L_WAIT && masterRetry |=> s_reissue)
    else $error("retried transfer not reissued");

  a_ready_ends: assert property (@(posedge lbus_clock)
    disable iff (linkRst) state == L_WAIT && masterDone |=>
      state == L_DROP && !lbus_addr_strobe_n_oe)
    else $error("transfer not ended by ready");

  a_hold_kept: assert property (@(posedge lbus_clock)
    disable iff (linkRst) state == L_WAIT |-> lbus_hold_request)
    else $error("hold request dropped mid transfer");

  // a queued word may be taken right after the pulse, so busy is
  // checked while the pulse stands, not one cycle later
  a_rsp_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    rspValid |-> !busy ##1 !rspValid)
    else $error("response not a single pulse");
endmodule

// ---- test/lbh_dev_model.sv ----
module lbh_dev_model (
  // device clock and straps
  input wire logic devClk,
  input wire logic speedSelN,
  input wire logic divRstN,
  output logic lclk,
  // ownership
  input wire logic hreq,
  output logic hack,
  // bus as seen at the device pins
  input wire lbh_pkg::lbh_addr_t aIn,
  input wire lbh_pkg::lbh_data_t dIn,
  input wire lbh_pkg::lbh_be_t beIn,
  input wire logic rwIn,
  input wire logic asIn,
  input wire logic rdyIn,
  input wire logic rtyIn,
  // device drivers
  output lbh_pkg::lbh_addr_t aOut,
  output lbh_pkg::lbh_data_t dOut,
  output logic rwOut,
  output logic asOut,
  output logic rtyOut,
  output logic mOe,
  output logic dOe,
  output logic rdyOe
);
  import lbh_pkg::*;
  logic [1:0] div = 2'h0;
  logic mReq = 1'h0;
  logic mRt, sWr, sdOe, rtyReq;
  int waits = 0;
  int sCnt;
  lbh_addr_t sA;
  lbh_be_t sBe;
  lbh_data_t sD, mD, mQ;
  lbh_data_t mem [4];
  wire logic start = mReq && !mOe && !hack && !(mRt && hreq);
  assign dOe = sdOe || (mOe && rwOut);

  initial begin
    {lclk, hack, mOe, mRt, sdOe, rdyOe, rtyReq} = 7'h0;
    {asOut, rtyOut} = 2'h3;
    sCnt = 0;
    foreach (mem[i])
      mem[i] = 32'h0;
  end

  // ********************
  // link clock
  // ********************
  // ratio from the strap, clock parked low under divider reset
  always @(posedge devClk) begin
    div <= divRstN ? div + 2'h1 : 2'h0;
    if (!divRstN)
      lclk <= 1'h0;
    else if (!speedSelN || div[0])
      lclk <= ~lclk;
  end

  // ********************
  // own transfers and grant
  // ********************
  // grant only between own transfers, kept while requested
  // strobe first cycle; after a retry wait for the bus
  always @(posedge lclk) begin
    hack <= hreq && (hack || !(mOe || start));
    if (start) begin
      mOe <= 1'h1;
      asOut <= 1'h0;
      dOut <= mD;
    end else if (mOe) begin
      asOut <= 1'h1;
      if (asOut && (!rdyIn || !rtyIn)) begin
        mOe <= 1'h0;
        mRt <= mRt || rdyIn;
        mReq <= rdyIn;
        mQ <= dIn;
      end
    end
  end

  task automatic master(input logic w, input lbh_addr_t a,
                        input lbh_data_t d);
    rwOut = w;
    aOut = a;
    mD = d;
    mRt = 1'h0;
    mReq = 1'h1;
  endtask

  // ********************
  // transfers from the external master
  // ********************
  // byte lanes into memory, clocked answers
  always @(posedge lclk) begin
    rdyOe <= 1'h0;
    sdOe <= 1'h0;
    rtyOut <= 1'h1;
    sCnt <= (sCnt > 0) ? sCnt - 1 : 0;
    if (hack && !asIn) begin
      {sWr, sA, sBe, sD} <= {rwIn, aIn, beIn, dIn};
      sCnt <= waits + 1;
    end else if (sCnt == 1 && rtyReq) begin
      rtyOut <= 1'h0;
      rtyReq <= 1'h0;
    end else if (sCnt == 1) begin
      rdyOe <= 1'h1;
      sdOe <= !sWr;
      dOut <= mem[sA[1:0]];
      for (int i = 0; i < 4; i++)
        if (sWr && !sBe[i])
          mem[sA[1:0]][8*i+:8] <= sD[8*i+:8];
    end
  end
endmodule

// ---- test/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lbh_pkg::*;
  logic sys_clk = 1'h0;
  logic devClk = 1'h0;
  logic srst = 1'h1;
  logic cfgSlowLink = 1'h0;
  logic testDividerReset = 1'h0;
  logic cmdValid = 1'h0;
  lbh_cmd_t cmdWord = 67'h0;
  logic [31:0] flt = 32'h5a5aa5a5;
  wire logic cmdReady, rspValid, rspRetried, spdN, divN, lclk, hreq, hack;
  wire lbh_data_t rspData, hD, dD;
  wire lbh_addr_t hA, dA;
  wire lbh_be_t hBe;
  wire logic hAoe, hDoe, hBoe, hRw, hRwOe, hAs, hAsOe, hRdy, hRdyOe, hRty;
  wire logic dRw, dAs, dRty, mOe, dDoe, dRdyOe;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int stalls = 0;

  // ********************
  // bus wires
  // ********************
  // released lines show a changing pattern; strobe and ready are pulled up
  wire lbh_addr_t bA = hAoe ? hA : mOe ? dA : flt[29:0];
  wire lbh_data_t bD = hDoe ? hD : dDoe ? dD : flt;
  wire lbh_be_t bBe = hBoe ? hBe : mOe ? 4'h0 : flt[3:0];
  wire logic bRw = hRwOe ? hRw : mOe ? dRw : flt[0];
  wire logic bAs = hAsOe ? hAs : mOe ? dAs : 1'h1;
  wire logic bRdy = hRdyOe ? hRdy : dRdyOe ? 1'h0 : 1'h1;

  initial forever #2 sys_clk = ~sys_clk;
  initial forever #3 devClk = ~devClk;
  always @(posedge lclk) flt <= ~flt;

  lbh_host #(.FIFO_DEPTH(4)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .cfgSlowLink(cfgSlowLink),
    .testDividerReset(testDividerReset), .lbus_speed_select_n(spdN),
    .lbus_divider_reset_n(divN), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWord(cmdWord), .rspValid(rspValid),
    .rspData(rspData), .rspRetried(rspRetried), .lbus_clock(lclk),
    .lbus_word_address_in(bA), .lbus_word_address_out(hA),
    .lbus_word_address_oe(hAoe), .lbus_data_in(bD),
    .lbus_data_out(hD), .lbus_data_oe(hDoe),
    .lbus_byte_enable_n_in(bBe), .lbus_byte_enable_n_out(hBe),
    .lbus_byte_enable_n_oe(hBoe), .lbus_read_write_n_in(bRw),
    .lbus_read_write_n_out(hRw), .lbus_read_write_n_oe(hRwOe),
    .lbus_addr_strobe_n_in(bAs), .lbus_addr_strobe_n_out(hAs),
    .lbus_addr_strobe_n_oe(hAsOe), .lbus_ready_n_in(bRdy),
    .lbus_ready_n_out(hRdy), .lbus_ready_n_oe(hRdyOe),
    .lbus_retry_n_in(dRty), .lbus_retry_n_out(hRty),
    .lbus_hold_request(hreq), .lbus_hold_ack(hack));

  lbh_dev_model u_dev (
    .devClk(devClk), .speedSelN(spdN), .divRstN(divN), .lclk(lclk),
    .hreq(hreq), .hack(hack), .aIn(bA), .dIn(bD), .beIn(bBe),
    .rwIn(bRw), .asIn(bAs), .rdyIn(bRdy), .rtyIn(hRty), .aOut(dA),
    .dOut(dD), .rwOut(dRw), .asOut(dAs), .rtyOut(dRty), .mOe(mOe),
    .dOe(dDoe), .rdyOe(dRdyOe));

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge lclk)
    if (!srst && ((!hack && (hAoe || hAsOe || hBoe)) || (hDoe && dDoe)))
      check(1'h0, 1'h1, "bus drive conflict");

  always @(posedge sys_clk)
    if (++cyc == 60000) begin
      n_mismatch++;
      results();
    end

  task automatic send(input logic w, input lbh_addr_t a,
                      input lbh_be_t be, input lbh_data_t d);
    int n;
    n = 0;
    cmdValid <= 1'h1;
    cmdWord <= {w, a, be, d};
    do begin
      @(posedge sys_clk);
      stalls += !cmdReady;
    end while (cmdReady !== 1'h1 && ++n < 2000);
  endtask

  task automatic rsp(output lbh_data_t q, output logic rt);
    int n;
    n = 0;
    do @(posedge sys_clk);
    while (rspValid !== 1'h1 && ++n < 4000);
    check(rspValid, 1'h1, "response");
    q = rspData;
    rt = rspRetried;
  endtask

  task automatic dwait();
    int n;
    n = 0;
    do @(posedge sys_clk);
    while (u_dev.mReq && ++n < 4000);
    check(u_dev.mReq, 1'h0, "device transfer end");
  endtask

  task automatic t_bytes();
    lbh_data_t q;
    logic rt;
    send(1'h1, 30'h1, 4'h5, 32'h11223344);
    send(1'h0, 30'h1, 4'h0, 32'h0);
    cmdValid <= 1'h0;
    rsp(q, rt);
    check(rt, 1'h0, "write retried");
    rsp(q, rt);
    check(q, 32'h11003300, "byte lanes");
    check(u_dev.sA, 30'h1, "word address");
    check(u_dev.sWr, 1'h0, "read level");
    $display("t_bytes done");
  endtask

  task automatic t_retry();
    lbh_data_t q;
    logic rt;
    u_dev.rtyReq = 1'h1;
    send(1'h0, 30'h1, 4'h0, 32'h0);
    cmdValid <= 1'h0;
    rsp(q, rt);
    check(rt, 1'h1, "retry flag");
    check(q, 32'h11003300, "reissued read");
    $display("t_retry done");
  endtask

  task automatic t_fifo();
    lbh_data_t q;
    logic rt;
    u_dev.waits = 20;
    stalls = 0;
    fork
      begin
        for (int i = 0; i < 8; i++)
          send(i < 4, 30'(i % 4), 4'h0, 32'h100 + i);
        cmdValid <= 1'h0;
      end
      for (int i = 0; i < 8; i++) begin
        rsp(q, rt);
        if (i >= 4)
          check(q, 32'h100 + i - 4, "queued order");
      end
    join
    check(stalls != 0, 1'h1, "queue refusal");
    u_dev.waits = 0;
    $display("t_fifo done");
  endtask

  task automatic t_slave();
    lbh_data_t q;
    logic rt;
    u_dev.master(1'h1, 30'h5, 32'hcafe0001);
    dwait();
    check(u_dev.mRt, 1'h0, "own write clean");
    send(1'h0, 30'h0, 4'h0, 32'h0);
    cmdValid <= 1'h0;
    @(posedge hreq);
    u_dev.master(1'h1, 30'h5, 32'hbeef0002);
    rsp(q, rt);
    check(q, 32'h100, "read beside contention");
    dwait();
    check(u_dev.mRt, 1'h1, "device retried");
    u_dev.master(1'h0, 30'h5, 32'h0);
    dwait();
    check(u_dev.mQ, 32'hbeef0002, "slave word");
    $display("t_slave done");
  endtask

  task automatic t_speed();
    realtime t0;
    lbh_data_t q;
    logic rt;
    check(spdN, 1'h0, "fast strap");
    check(divN, 1'h1, "divider run");
    @(posedge lclk) t0 = $realtime;
    @(posedge lclk) check(int'($realtime - t0), 32'hc, "fast period");
    @(posedge sys_clk);
    cfgSlowLink <= 1'h1;
    repeat (40) @(posedge sys_clk);
    check(spdN, 1'h1, "slow strap");
    @(posedge lclk) t0 = $realtime;
    @(posedge lclk) check(int'($realtime - t0), 32'h18, "slow period");
    @(posedge sys_clk);
    send(1'h0, 30'h1, 4'h0, 32'h0);
    cmdValid <= 1'h0;
    rsp(q, rt);
    check(q, 32'h101, "slow read");
    testDividerReset <= 1'h1;
    repeat (20) @(posedge sys_clk);
    check(divN, 1'h0, "divider held");
    check(lclk, 1'h0, "clock parked");
    testDividerReset <= 1'h0;
    cfgSlowLink <= 1'h0;
    repeat (40) @(posedge sys_clk);
    $display("t_speed done");
  endtask

  initial begin
    // link reset passes four flops, so hold well past five link edges
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    t_bytes();
    t_retry();
    t_fifo();
    t_slave();
    t_speed();
    results();
  end
endmodule
